// File: rtl/efei_map.vh
// Register offsets, field positions, reset values and timing constants of the E1 event block.
// Functional notes
// R1: While CRC multiframe in sync, count CRC-4 errors per one-second window; flag at 915.
// R2: Excessive CRC-4 detection is suspended while CRC multiframe sync is lost.
// R3: Any edge on each of five sync status bits sets its change flag.
// R4: Flags stay set until software writes one to the bit; zero leaves them.
// R5: Each flag has a read-write enable, reset zero; interrupt only for enabled set flags.
// R6: Signaling multiframe start sets a flag, not updated while that sync is lost.
// R7: CRC sub-multiframe start sets a flag, not updated while CRC sync is lost.
// R8: CRC multiframe start sets a flag, not updated while CRC sync is lost.
// R9: In signaling sync, a non-0000 alignment nibble raises one pattern error.
// R10: In CRC sync, a non-001011 alignment signal raises one pattern error.
// R11: In CRC sync, CRC-4 over a sub-multiframe mismatching next carried bits raises error.
// R12: In basic frame sync, alignment errors raise events per configured criteria.
// R13: A new alignment position differing from the held one sets the position flag.
// R14: International bit of non-alignment frames goes to bit 7, held out of sync.
// R15: International bit of alignment frames goes to bit 6, held out of sync.
// R16: Excess CRC flag is bit 5; change flags bits 4..0; bits 7,6 reserved.
// R17: Remote alarm bit of non-alignment frames goes to bit 5, held out of sync.
// R18: Five national bits of non-alignment frames go to bits 4..0, held out of sync.
// R19: Default counts each alignment bit error; word mode counts patterns; option adds NFAS errors. Code: one event per bad FAS word in both modes.
// R20: An event in the same cycle as a clearing write keeps the flag set.
// R21: Interrupt output is active low OR of enabled set flags.
`ifndef EFEI_MAP_VH
`define EFEI_MAP_VH
`define EFEI_ADDR_W 8
`define EFEI_IDX_EN1 8'h51
`define EFEI_IDX_FLG0 8'h52
`define EFEI_IDX_FLG1 8'h53
`define EFEI_IDX_TS0 8'h54
`define EFEI_IDX_CFG 8'h60
`define EFEI_IDX_EN0 8'h61
`define EFEI_IDX_STAT 8'h62
`define EFEI_CFG_WORD 0
`define EFEI_CFG_NFAS 1
`define EFEI_ST_BFRAME 0
`define EFEI_ST_CRCMF 2
`define EFEI_ST_SIGMF 3
`define EFEI_F1_ALPOS 0
`define EFEI_F1_ALERR 1
`define EFEI_F1_CRCERR 2
`define EFEI_F1_CMFERR 3
`define EFEI_F1_CMFST 4
`define EFEI_F1_SMFERR 5
`define EFEI_F1_SUBST 6
`define EFEI_F1_SMFST 7
`define EFEI_F0_EXCESS 5
`define EFEI_F0_MASK 8'h3f
`define EFEI_TS_SI_NF 7
`define EFEI_TS_SI_FA 6
`define EFEI_TS_RAI 5
`define EFEI_TS_NAT_HI 4
`define EFEI_RST8 8'h00
`define EFEI_ST_RST 5'h0d
`define EFEI_SMF_PATTERN 4'h0
`define EFEI_CMF_PATTERN 6'h0b
`define EFEI_FAS_PATTERN 7'h1b
`define EFEI_CRC_LIMIT 10'd915
`define EFEI_WINDOW_MS 1000
`define EFEI_CLK_KHZ 50000
`endif

// File: rtl/efei_top.v
// E1 receive framer event flags, enables, interrupt and AHB-Lite register slave.
`timescale 1ns/1ps
`include "efei_map.vh"
module efei_top #(
    parameter WINDOW_CYCLES = `EFEI_WINDOW_MS * `EFEI_CLK_KHZ
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire [4:0] sync_status,
    input wire sig_mf_start,
    input wire sig_mf_nibble_valid,
    input wire [3:0] sig_mf_nibble,
    input wire crc_submf_start,
    input wire crc_mf_start,
    input wire crc_mfas_valid,
    input wire [5:0] crc_mfas,
    input wire crc4_valid,
    input wire [3:0] crc4_calc,
    input wire [3:0] crc4_rx,
    input wire fas_valid,
    input wire [6:0] fas_word,
    input wire nfas_valid,
    input wire nfas_bit2,
    input wire [7:0] nfas_ts0,
    input wire fas_si,
    input wire align_found,
    input wire [8:0] align_pos,
    output wire int_n
);
    // Status bits: 4 interworking, 3 sig mf lost, 2 crc mf lost, 1 offline lost, 0 basic lost.
    reg [4:0] st_s1_r, st_s2_r, st_prev_r;
    reg [7:0] en0_r, en1_r, flg0_r, flg1_r, ts0_r;
    reg [1:0] cfg_r;
    reg wr_pend_r;
    reg [7:0] wr_idx_r;
    reg [31:0] win_cnt_r;
    reg [9:0] crc_cnt_r;
    reg [8:0] pos_r;
    reg pos_valid_r;
    reg [7:0] flg0_nxt, flg1_nxt;
    wire sig_sync, crc_sync, bf_sync, win_end, excess_ev;
    wire [7:0] ev1, clr0, clr1;
    wire [2:0] fas_bit_errs;
    wire fas_err_ev, nfas_err_ev;
    wire [1:0] fas_events;
    wire acc;

    function [2:0] popcnt7;
        input [6:0] v;
        integer i;
        begin
            popcnt7 = 3'd0;
            for (i = 0; i < 7; i = i + 1) begin
                popcnt7 = popcnt7 + {2'b00, v[i]};
            end
        end
    endfunction

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_s1_r <= `EFEI_ST_RST;
            st_s2_r <= `EFEI_ST_RST;
            st_prev_r <= `EFEI_ST_RST;
        end else begin
            st_s1_r <= sync_status;
            st_s2_r <= st_s1_r;
            st_prev_r <= st_s2_r;
        end
    end

    assign sig_sync = ~st_s2_r[`EFEI_ST_SIGMF];
    assign crc_sync = ~st_s2_r[`EFEI_ST_CRCMF];
    assign bf_sync = ~st_s2_r[`EFEI_ST_BFRAME];

    // Fixed one-second window; errors only counted while CRC multiframe is in sync.
    assign win_end = (win_cnt_r == WINDOW_CYCLES - 1);
    assign excess_ev = crc_sync && crc4_valid && (crc4_calc != crc4_rx) &&
                       (crc_cnt_r == `EFEI_CRC_LIMIT - 10'd1); // see R1
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            win_cnt_r <= 32'h0;
            crc_cnt_r <= 10'h0;
        end else begin
            win_cnt_r <= win_end ? 32'h0 : win_cnt_r + 32'h1;
            if (win_end || !crc_sync) begin
                crc_cnt_r <= 10'h0; // see R2
            end else if (crc4_valid && crc4_calc != crc4_rx &&
                         crc_cnt_r != `EFEI_CRC_LIMIT) begin
                crc_cnt_r <= crc_cnt_r + 10'h1; // see R1
            end
        end
    end

    // Alignment error events: one per errored FAS word in either mode, optionally plus NFAS bit errors.
    assign fas_bit_errs = popcnt7(fas_word ^ `EFEI_FAS_PATTERN);
    assign fas_err_ev = bf_sync && fas_valid && (fas_bit_errs != 3'd0);
    assign nfas_err_ev = bf_sync && nfas_valid && !nfas_bit2 && cfg_r[`EFEI_CFG_NFAS]; // see R19
    assign fas_events = {1'b0, fas_err_ev} | {1'b0, nfas_err_ev};

    assign ev1[`EFEI_F1_SMFST] = sig_sync && sig_mf_start; // see R6
    assign ev1[`EFEI_F1_SUBST] = crc_sync && crc_submf_start; // see R7
    assign ev1[`EFEI_F1_SMFERR] = sig_sync && sig_mf_nibble_valid &&
                                  (sig_mf_nibble != `EFEI_SMF_PATTERN); // see R9
    assign ev1[`EFEI_F1_CMFST] = crc_sync && crc_mf_start; // see R8
    assign ev1[`EFEI_F1_CMFERR] = crc_sync && crc_mfas_valid &&
                                  (crc_mfas != `EFEI_CMF_PATTERN); // see R10
    assign ev1[`EFEI_F1_CRCERR] = crc_sync && crc4_valid && (crc4_calc != crc4_rx); // see R11
    assign ev1[`EFEI_F1_ALERR] = fas_events[0]; // see R12
    assign ev1[`EFEI_F1_ALPOS] = align_found && pos_valid_r && (align_pos != pos_r); // see R13

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos_r <= 9'h0;
            pos_valid_r <= 1'b0;
            ts0_r <= `EFEI_RST8;
        end else begin
            if (align_found) begin
                pos_r <= align_pos;
                pos_valid_r <= 1'b1;
            end
            if (bf_sync && nfas_valid) begin
                ts0_r[`EFEI_TS_SI_NF] <= nfas_ts0[`EFEI_TS_SI_NF]; // see R14
                ts0_r[`EFEI_TS_RAI] <= nfas_ts0[`EFEI_TS_RAI]; // see R17
                ts0_r[`EFEI_TS_NAT_HI:0] <= nfas_ts0[`EFEI_TS_NAT_HI:0]; // see R18
            end
            if (bf_sync && fas_valid) begin
                ts0_r[`EFEI_TS_SI_FA] <= fas_si; // see R15
            end
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY; registers at word index times four.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign acc = hsel && hready && htrans[1];
    assign clr0 = (wr_pend_r && wr_idx_r == `EFEI_IDX_FLG0) ? hwdata[7:0] : 8'h00;
    assign clr1 = (wr_pend_r && wr_idx_r == `EFEI_IDX_FLG1) ? hwdata[7:0] : 8'h00;

    always @* begin
        flg0_nxt = flg0_r & ~clr0; // see R4
        flg0_nxt[4:0] = flg0_nxt[4:0] | (st_s2_r ^ st_prev_r); // see R3
        flg0_nxt[`EFEI_F0_EXCESS] = flg0_nxt[`EFEI_F0_EXCESS] | excess_ev; // see R16
        flg0_nxt = flg0_nxt & `EFEI_F0_MASK; // see R16
        flg1_nxt = (flg1_r & ~clr1) | ev1; // see R20
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_idx_r <= 8'h0;
            hrdata <= 32'h0;
            en0_r <= `EFEI_RST8;
            en1_r <= `EFEI_RST8;
            cfg_r <= 2'b00;
            flg0_r <= `EFEI_RST8;
            flg1_r <= `EFEI_RST8;
        end else begin
            flg0_r <= flg0_nxt;
            flg1_r <= flg1_nxt;
            wr_pend_r <= acc && hwrite;
            wr_idx_r <= haddr[`EFEI_ADDR_W+1:2];
            if (wr_pend_r) begin
                case (wr_idx_r)
                    `EFEI_IDX_EN1: en1_r <= hwdata[7:0]; // see R5
                    `EFEI_IDX_EN0: en0_r <= hwdata[7:0] & `EFEI_F0_MASK; // see R5
                    `EFEI_IDX_CFG: cfg_r <= hwdata[1:0];
                    default: cfg_r <= cfg_r;
                endcase
            end
            if (acc && !hwrite) begin
                case (haddr[`EFEI_ADDR_W+1:2])
                    `EFEI_IDX_EN1: hrdata <= {24'h0, en1_r};
                    `EFEI_IDX_FLG0: hrdata <= {24'h0, flg0_r};
                    `EFEI_IDX_FLG1: hrdata <= {24'h0, flg1_r};
                    `EFEI_IDX_TS0: hrdata <= {24'h0, ts0_r};
                    `EFEI_IDX_CFG: hrdata <= {30'h0, cfg_r};
                    `EFEI_IDX_EN0: hrdata <= {24'h0, en0_r};
                    `EFEI_IDX_STAT: hrdata <= {27'h0, st_s2_r};
                    default: hrdata <= 32'h0;
                endcase
            end
        end
    end

    assign int_n = ~(|(flg0_r & en0_r) | |(flg1_r & en1_r)); // see R21
endmodule

// File: dv/efei_monitor.sv
// Port-level checker for the E1 event flag and interrupt block.
`timescale 1ns/1ps
module efei_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic int_n
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic ap;
    logic wd_r;
    logic rd_r;
    assign ap = hsel && hready && htrans[1];
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wd_r <= 1'b0;
            rd_r <= 1'b0;
        end else begin
            wd_r <= ap && hwrite;
            rd_r <= ap && !hwrite;
        end
    end
    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("hresp not okay");
    a_int_reset: assert property ($rose(hresetn) |-> int_n) else $error("int_n low");
    a_rel_write: assert property ($rose(int_n) |-> $past(wd_r)) else $error("int_n rose");
    a_low_holds: assert property (!int_n && !wd_r |=> !int_n) else $error("int_n left");
    a_upper_zero: assert property (rd_r |-> hrdata[31:8] == 24'h0) else $error("upper");
    a_rdata_holds: assert property (!rd_r |-> $stable(hrdata)) else $error("hrdata moved");
    a_hole_zero: assert property (ap && !hwrite && haddr[9:2] == 8'h55 |=> hrdata == 32'h0)
        else $error("unmapped read");
    cover property ($fell(int_n));
    cover property ($rose(int_n));
    cover property (wd_r);
endmodule
bind efei_top efei_monitor efei_monitor_i (.*);

// File: dv/efei_host.sv
// Host model: AHB-Lite master issuing single word transfers.
`timescale 1ns/1ps
module efei_host (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel = 1'b0,
    output logic [31:0] haddr = 32'h0,
    output logic [1:0] htrans = 2'h0,
    output logic hwrite = 1'b0,
    output logic [2:0] hsize = 3'h2,
    output logic [31:0] hwdata = 32'h0,
    output logic tmo = 1'b0
);
    task automatic wait_rdy();
        int n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (hready !== 1'b1) tmo <= 1'b1;
    endtask
    task automatic xfer(input logic w, input logic [7:0] ix, input logic [7:0] wd,
            output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, ix, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_rdy();
        rd = hrdata;
        hwdata <= ~hwdata;
    endtask
endmodule

// File: dv/e1_framer_event_interrupts_tb.sv
// Self-checking bench for the E1 event flag and interrupt block.
`timescale 1ns/1ps
module e1_framer_event_interrupts_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, int_n, hreadyout, hresp, tmo, sms, sbs, smv, cms, cmv, c4v, fv, nv, nb2;
    logic fsi, alf;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [4:0] ss;
    logic [3:0] nib, cc, cr;
    logic [5:0] mfas;
    logic [6:0] fw;
    logic [7:0] n8, m, t;
    logic [8:0] ap;
    int error_cnt = 0;
    int comparisons = 0;
    always #10 hclk = ~hclk;
    efei_top #(.WINDOW_CYCLES(4000)) efei_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sync_status(ss), .sig_mf_start(sms), .sig_mf_nibble_valid(smv), .sig_mf_nibble(nib),
        .crc_submf_start(sbs), .crc_mf_start(cms), .crc_mfas_valid(cmv), .crc_mfas(mfas),
        .crc4_valid(c4v), .crc4_calc(cc), .crc4_rx(cr), .fas_valid(fv), .fas_word(fw),
        .nfas_valid(nv), .nfas_bit2(nb2), .nfas_ts0(n8), .fas_si(fsi), .align_found(alf),
        .align_pos(ap), .int_n(int_n));
    efei_host efei_host_i (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .tmo(tmo));
    function automatic logic [31:0] exp1(int i, logic hit);
        return hit ? 32'h1 << i : 32'h0;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic rdc(input logic [7:0] ix, input logic [31:0] e);
        efei_host_i.xfer(1'b0, ix, 8'h00, d);
        chk($sformatf("reg %h", ix), e, d);
    endtask
    task automatic sync(input logic [4:0] v);
        ss <= v;
        repeat (6) @(posedge hclk);
    endtask
    task automatic fire(int i, logic hit);
        logic [6:0] r;
        r = 7'($urandom_range(1, 127));
        sync(hit ? 5'h00 : 5'h0d);
        case (i)
            7: sms <= 1'b1;
            6: sbs <= 1'b1;
            5: {smv, nib} <= {1'b1, r[3:0] | 4'h1};
            4: cms <= 1'b1;
            3: {cmv, mfas} <= {1'b1, 6'h0b ^ (r[5:0] | 6'h01)};
            2: {c4v, cc, cr} <= {1'b1, r[3:0], ~r[3:0]};
            1: {fv, fw} <= {1'b1, 7'h1b ^ r};
            default: {alf, ap} <= {1'b1, 2'b00, hit ? ap[6:0] + r : r};
        endcase
        @(posedge hclk);
        {sms, sbs, smv, cms, cmv, c4v, fv, alf} <= 8'h00;
        rdc(8'h53, exp1(i, hit));
        efei_host_i.xfer(1'b1, 8'h53, 8'hff, d);
        rdc(8'h53, 32'h0);
    endtask
    task automatic tally_and_finish();
        if (tmo) error_cnt++;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge tmo) tally_and_finish();
    initial begin
        {sms, sbs, smv, cms, cmv, c4v, fv, nv, nb2, fsi, alf, nib, cc, cr, mfas, fw, n8, ap} = '0;
        ss = 5'h0d;
        void'($urandom(32'h5f35));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        for (int k = 8'h51; k < 8'h56; k++) rdc(8'(k), 32'h0);
        efei_host_i.xfer(1'b1, 8'h61, 8'h3f, d);
        sync(5'h00);
        rdc(8'h52, 32'h0d);
        #1 chk("int_n", 1'b0, int_n);
        m = 8'($urandom);
        efei_host_i.xfer(1'b1, 8'h52, m, d);
        rdc(8'h52, {24'h0, 8'h0d & ~m});
        efei_host_i.xfer(1'b1, 8'h52, 8'hff, d);
        #1 chk("int_n", 1'b1, int_n);
        efei_host_i.xfer(1'b1, 8'h61, 8'h00, d);
        for (int i = 0; i < 16; i++) fire(i / 2, 1'(i % 2));
        for (int h = 0; h < 2; h++) begin
            sync(h ? 5'h00 : 5'h04);
            efei_host_i.xfer(1'b1, 8'h52, 8'hff, d);
            repeat (2000) begin
                m = 8'($urandom);
                {c4v, cc, cr} <= {1'b1, m[3:0], ~m[3:0]};
                @(posedge hclk);
            end
            c4v <= 1'b0;
            rdc(8'h52, h ? 32'h20 : 32'h0);
        end
        for (int k = 0; k < 4; k++) begin
            sync(k < 2 ? 5'h00 : 5'h01);
            m = 8'($urandom);
            {nv, n8, nb2, fv, fw, fsi} <= {1'b1, m, m[6], 1'b1, 7'h1b, m[0]};
            if (k < 2) t = {m[7], m[0], m[5:0]};
            @(posedge hclk);
            {nv, fv} <= 2'b00;
            rdc(8'h54, {24'h0, t});
        end
        efei_host_i.xfer(1'b1, 8'h60, 8'h02, d);
        efei_host_i.xfer(1'b1, 8'h51, 8'h02, d);
        rdc(8'h60, 32'h2);
        rdc(8'h51, 32'h2);
        sync(5'h00);
        rdc(8'h62, 32'h0);
        efei_host_i.xfer(1'b1, 8'h53, 8'hff, d);
        {nv, nb2} <= 2'b10;
        @(posedge hclk);
        nv <= 1'b0;
        rdc(8'h53, 32'h2);
        #1 chk("int_n", 1'b0, int_n);
        efei_host_i.xfer(1'b1, 8'h53, 8'h02, d);
        #1 chk("int_n", 1'b1, int_n);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(8'h60, 32'h0);
        rdc(8'h51, 32'h0);
        tally_and_finish();
    end
endmodule
